// ==== src/cmf_consts.vh ====
// constants for the core memory map, return stack and flag logic
// Notes on behaviour
// - return stack: 16 entries, 15 bits each
// - overflow and underflow set power control flags
// - stack error resets device when enabled
// - two 16-bit pointers reach data and program
// - pointer read of program costs one extra cycle over a data read
// - 15-bit program counter, 32K by 14 space
// - addresses wrap inside 4096 implemented words
// - reset starts at 0000h, interrupt at 0004h
// - pointer high bit 7 selects program memory
// - program read returns low 8 word bits
// - pointer writes never change program memory
// - data memory is 32 banks of 128
// - direct access uses the bank select register
// - unimplemented data locations read as zero
// - first 12 bank addresses are core registers; 09h and 0Bh are passed on to data memory
// - flag-updating instruction overrides status flag writes
// - timeout and sleep bits read-only, 7:5 zero
// - timeout bit: set clear/sleep, cleared timeout
// - sleep bit: set clear op, cleared sleep
// - zero flag follows arithmetic or logic result
// - digit carry from bit 3, carry from 7
// - subtract adds two's complement, carries are inverted borrows
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH
`define CMF_PC_W 15
`define CMF_RESET_VEC 15'h0000
`define CMF_INT_VEC 15'h0004
`define CMF_PC_MASK 15'h0fff
`define CMF_STACK_DEPTH 16
`define CMF_DMEM_LAST 16'h0fff
`define CMF_PROG_BIT 15
`define CMF_OFS_IND0 7'h00
`define CMF_OFS_IND1 7'h01
`define CMF_OFS_PCL 7'h02
`define CMF_OFS_STATUS 7'h03
`define CMF_OFS_FP0L 7'h04
`define CMF_OFS_FP0H 7'h05
`define CMF_OFS_FP1L 7'h06
`define CMF_OFS_FP1H 7'h07
`define CMF_OFS_BSR 7'h08
`define CMF_OFS_WREG 7'h09
`define CMF_OFS_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define CMF_OFS_INTCON 7'h0b
`define CMF_ST_TO 4
`define CMF_ST_PD 3
`define CMF_ST_Z 2
`define CMF_ST_DC 1
`define CMF_ST_C 0
`define CMF_STATUS_RST 5'h18
`define CMF_OP_ADD 2'h0
`define CMF_OP_SUB 2'h1
`define CMF_OP_LOGIC 2'h2
`endif

// ==== src/cmf_return_stack.v ====
// return address stack with overflow and underflow detection
`timescale 1ns/1ps
`include "cmf_consts.vh"

module cmf_return_stack #(
    parameter DEPTH = `CMF_STACK_DEPTH,
    parameter IDX_W = 4,
    parameter WIDTH = `CMF_PC_W
) (
    input wire core_clk,
    input wire nrst,
    input wire push,
    input wire pop,
    input wire [WIDTH-1:0] push_data,
    output wire [WIDTH-1:0] pop_data,
    output reg overflow,
    output reg underflow
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [IDX_W-1:0] idx;
    reg [IDX_W:0] count;
    wire [IDX_W-1:0] idx_below;

    assign idx_below = idx - {{(IDX_W-1){1'b0}}, 1'b1};
    // top entry is the one just below the write index
    assign pop_data = mem[idx_below];

    // storage; a push always writes, overflow wraps onto oldest entry
    always @(posedge core_clk) begin
        if (push) begin
            mem[idx] <= push_data;
        end
    end

    // index, fill count and error pulses
    always @(posedge core_clk) begin
        if (!nrst) begin
            idx <= {IDX_W{1'b0}};
            count <= {(IDX_W+1){1'b0}};
            overflow <= 1'b0;
            underflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            underflow <= 1'b0;
            if (push) begin
                idx <= idx + {{(IDX_W-1){1'b0}}, 1'b1};
                if (count == DEPTH[IDX_W:0]) begin
                    overflow <= 1'b1;
                end else begin
                    count <= count + {{IDX_W{1'b0}}, 1'b1};
                end
            end else if (pop) begin
                idx <= idx_below;
                if (count == {(IDX_W+1){1'b0}}) begin
                    underflow <= 1'b1;
                end else begin
                    count <= count - {{IDX_W{1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ==== src/cmf_core_map.v ====
// program counter, pointers, banked data access and status flags
`timescale 1ns/1ps
`include "cmf_consts.vh"

module cmf_core_map #(
    parameter PC_W = `CMF_PC_W
) (
    input wire core_clk,
    input wire nrst,
    input wire pc_step,
    input wire pc_jump,
    input wire pc_call,
    input wire pc_return,
    input wire int_entry,
    input wire [PC_W-1:0] pc_target,
    output reg [PC_W-1:0] prog_counter,
    input wire stack_err_reset_en,
    input wire stack_flag_clear,
    output reg stack_overflow_flag,
    output reg stack_underflow_flag,
    output reg soft_reset,
    input wire access_req,
    input wire access_ind,
    input wire access_ptr,
    input wire access_wr,
    input wire [6:0] access_addr,
    input wire [7:0] access_wdata,
    output reg access_busy,
    output reg access_done,
    output reg [7:0] access_rdata,
    output reg [11:0] dmem_addr,
    output reg dmem_rd,
    output reg dmem_we,
    output reg [7:0] dmem_wdata,
    input wire [7:0] dmem_rdata,
    input wire dmem_impl,
    output reg [PC_W-1:0] pmem_addr,
    output reg pmem_rd,
    input wire [13:0] pmem_rdata,
    input wire flag_upd,
    input wire [1:0] flag_op,
    input wire [7:0] flag_a,
    input wire [7:0] flag_b,
    input wire [7:0] flag_logic_res,
    input wire watchdog_clear_op,
    input wire sleep_op,
    input wire watchdog_timeout,
    output reg [7:0] arith_and_reset_flags,
    output reg [4:0] bank_select_reg
);
    localparam S_IDLE = 2'h0;
    localparam S_DMEM = 2'h1;
    localparam S_PMEM1 = 2'h2;
    localparam S_PMEM2 = 2'h3;

    reg [1:0] state;
    reg [15:0] file_pointer [0:1];
    reg [6:0] program_counter_latch_high;
    reg dmem_ok;

    wire [PC_W-1:0] stack_top;
    wire stk_ovf;
    wire stk_unf;
    wire stk_push;
    wire stk_pop;
    wire [PC_W-1:0] stk_push_data;
    wire [PC_W-1:0] pc_next_seq;

    reg use_ptr;
    reg ptr_sel;
    reg [15:0] ptr_val;
    reg [15:0] eff_addr;
    reg is_prog;
    reg is_core;
    reg out_range;
    reg [7:0] core_rdata;
    reg pcl_wr;
    reg status_wr;
    reg [8:0] sum9;
    reg [4:0] sum5;
    reg [7:0] b_eff;
    reg cin;
    reg next_z;
    reg next_dc;
    reg next_c;

    assign pc_next_seq = (prog_counter + {{(PC_W-1){1'b0}}, 1'b1})
                         & `CMF_PC_MASK;
    assign stk_push = int_entry | pc_call;
    assign stk_pop = pc_return & ~stk_push;
    assign stk_push_data = int_entry ? prog_counter : pc_next_seq;

    cmf_return_stack #(
        .DEPTH(`CMF_STACK_DEPTH),
        .IDX_W(4),
        .WIDTH(PC_W)
    ) u_stack (
        .core_clk(core_clk),
        .nrst(nrst),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(stk_push_data),
        .pop_data(stack_top),
        .overflow(stk_ovf),
        .underflow(stk_unf)
    );

    // access decode: pick pointer or bank, classify the target
    always @* begin
        use_ptr = access_ind | (access_addr == `CMF_OFS_IND0)
                  | (access_addr == `CMF_OFS_IND1);
        ptr_sel = access_ind ? access_ptr : access_addr[0];
        ptr_val = file_pointer[ptr_sel];
        if (use_ptr) begin
            eff_addr = {1'b0, ptr_val[14:0]};
        end else begin
            eff_addr = {4'h0, bank_select_reg, access_addr};
        end
        is_prog = use_ptr & ptr_val[`CMF_PROG_BIT];
        out_range = eff_addr > `CMF_DMEM_LAST;
        // core registers appear at the bottom of every bank
        is_core = (eff_addr[6:0] <= `CMF_OFS_INTCON)
                  & (eff_addr[6:0] != `CMF_OFS_WREG)
                  & (eff_addr[6:0] != `CMF_OFS_INTCON);
        core_rdata = 8'h00;
        if (eff_addr[6:0] == `CMF_OFS_PCL) begin
            core_rdata = prog_counter[7:0];
        end else if (eff_addr[6:0] == `CMF_OFS_STATUS) begin
            core_rdata = arith_and_reset_flags;
        end else if (eff_addr[6:0] == `CMF_OFS_FP0L) begin
            core_rdata = file_pointer[0][7:0];
        end else if (eff_addr[6:0] == `CMF_OFS_FP0H) begin
            core_rdata = file_pointer[0][15:8];
        end else if (eff_addr[6:0] == `CMF_OFS_FP1L) begin
            core_rdata = file_pointer[1][7:0];
        end else if (eff_addr[6:0] == `CMF_OFS_FP1H) begin
            core_rdata = file_pointer[1][15:8];
        end else if (eff_addr[6:0] == `CMF_OFS_BSR) begin
            core_rdata = {3'h0, bank_select_reg};
        end else if (eff_addr[6:0] == `CMF_OFS_PROGRAM_COUNTER_LATCH_HIGH) begin
            core_rdata = {1'h0, program_counter_latch_high};
        end
        pcl_wr = 1'b0;
        status_wr = 1'b0;
        if ((state == S_IDLE) && access_req && access_wr && !is_prog
            && !out_range && is_core) begin
            pcl_wr = eff_addr[6:0] == `CMF_OFS_PCL;
            status_wr = eff_addr[6:0] == `CMF_OFS_STATUS;
        end
    end

    // access sequencer: local core, external data, program read
    always @(posedge core_clk) begin
        if (!nrst) begin
            state <= S_IDLE;
            access_busy <= 1'b0;
            access_done <= 1'b0;
            access_rdata <= 8'h00;
            dmem_addr <= 12'h000;
            dmem_rd <= 1'b0;
            dmem_we <= 1'b0;
            dmem_wdata <= 8'h00;
            dmem_ok <= 1'b0;
            pmem_addr <= `CMF_RESET_VEC;
            pmem_rd <= 1'b0;
        end else begin
            access_done <= 1'b0;
            dmem_rd <= 1'b0;
            dmem_we <= 1'b0;
            pmem_rd <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (access_req) begin
                        if (is_prog) begin
                            if (access_wr) begin
                                access_done <= 1'b1;
                            end else begin
                                pmem_addr <= ptr_val[PC_W-1:0]
                                             & `CMF_PC_MASK;
                                pmem_rd <= 1'b1;
                                access_busy <= 1'b1;
                                state <= S_PMEM1;
                            end
                        end else if (out_range) begin
                            access_rdata <= 8'h00;
                            access_done <= 1'b1;
                        end else if (is_core) begin
                            access_rdata <= access_wr ? 8'h00 : core_rdata;
                            access_done <= 1'b1;
                        end else begin
                            dmem_addr <= eff_addr[11:0];
                            dmem_rd <= ~access_wr;
                            dmem_we <= access_wr;
                            dmem_wdata <= access_wdata;
                            dmem_ok <= ~access_wr;
                            access_busy <= 1'b1;
                            state <= S_DMEM;
                        end
                    end
                end
                S_DMEM: begin
                    access_rdata <= (dmem_ok && dmem_impl)
                                    ? dmem_rdata : 8'h00;
                    access_done <= 1'b1;
                    access_busy <= 1'b0;
                    state <= S_IDLE;
                end
                S_PMEM1: begin
                    state <= S_PMEM2;
                end
                default: begin
                    access_rdata <= pmem_rdata[7:0];
                    access_done <= 1'b1;
                    access_busy <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // pointer, bank and latch registers written as file registers
    always @(posedge core_clk) begin
        if (!nrst) begin
            file_pointer[0] <= 16'h0000;
            file_pointer[1] <= 16'h0000;
            bank_select_reg <= 5'h00;
            program_counter_latch_high <= 7'h00;
        end else if ((state == S_IDLE) && access_req && access_wr
                     && !is_prog && !out_range && is_core) begin
            if (eff_addr[6:0] == `CMF_OFS_FP0L) begin
                file_pointer[0][7:0] <= access_wdata;
            end else if (eff_addr[6:0] == `CMF_OFS_FP0H) begin
                file_pointer[0][15:8] <= access_wdata;
            end else if (eff_addr[6:0] == `CMF_OFS_FP1L) begin
                file_pointer[1][7:0] <= access_wdata;
            end else if (eff_addr[6:0] == `CMF_OFS_FP1H) begin
                file_pointer[1][15:8] <= access_wdata;
            end else if (eff_addr[6:0] == `CMF_OFS_BSR) begin
                bank_select_reg <= access_wdata[4:0];
            end else if (eff_addr[6:0] == `CMF_OFS_PROGRAM_COUNTER_LATCH_HIGH) begin
                program_counter_latch_high <= access_wdata[6:0];
            end
        end
    end

    // program counter: interrupt, call or jump, return, PCL write, step
    always @(posedge core_clk) begin
        if (!nrst) begin
            prog_counter <= `CMF_RESET_VEC;
        end else if (int_entry) begin
            prog_counter <= `CMF_INT_VEC;
        end else if (pc_call || pc_jump) begin
            prog_counter <= pc_target & `CMF_PC_MASK;
        end else if (pc_return) begin
            prog_counter <= stack_top & `CMF_PC_MASK;
        end else if (pcl_wr) begin
            prog_counter <= {program_counter_latch_high, access_wdata}
                            & `CMF_PC_MASK;
        end else if (pc_step) begin
            prog_counter <= pc_next_seq;
        end
    end

    // stack error flags are sticky, a new error beats the clear
    always @(posedge core_clk) begin
        if (!nrst) begin
            stack_overflow_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            stack_overflow_flag <= stk_ovf
                | (stack_overflow_flag & ~stack_flag_clear);
            stack_underflow_flag <= stk_unf
                | (stack_underflow_flag & ~stack_flag_clear);
            soft_reset <= stack_err_reset_en & (stk_ovf | stk_unf);
        end
    end

    // flag arithmetic; subtraction adds the two's complement
    always @* begin
        b_eff = (flag_op == `CMF_OP_SUB) ? ~flag_b : flag_b;
        cin = flag_op == `CMF_OP_SUB;
        sum9 = {1'b0, flag_a} + {1'b0, b_eff} + {8'h00, cin};
        sum5 = {1'b0, flag_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        next_dc = sum5[4];
        next_c = sum9[8];
        if (flag_op == `CMF_OP_LOGIC) begin
            next_z = flag_logic_res == 8'h00;
        end else begin
            next_z = sum9[7:0] == 8'h00;
        end
    end

    // status register: flags, timeout and sleep bits
    always @(posedge core_clk) begin
        if (!nrst) begin
            arith_and_reset_flags <= {3'h0, `CMF_STATUS_RST};
        end else begin
            arith_and_reset_flags[7:5] <= 3'h0;
            if (flag_upd) begin
                arith_and_reset_flags[`CMF_ST_Z] <= next_z;
                if (flag_op != `CMF_OP_LOGIC) begin
                    arith_and_reset_flags[`CMF_ST_DC] <= next_dc;
                    arith_and_reset_flags[`CMF_ST_C] <= next_c;
                end
            end else if (status_wr) begin
                arith_and_reset_flags[2:0] <= access_wdata[2:0];
            end
            // software writes never reach bits 4 and 3
            if (watchdog_clear_op || sleep_op) begin
                arith_and_reset_flags[`CMF_ST_TO] <= 1'b1;
            end else if (watchdog_timeout) begin
                arith_and_reset_flags[`CMF_ST_TO] <= 1'b0;
            end
            if (watchdog_clear_op) begin
                arith_and_reset_flags[`CMF_ST_PD] <= 1'b1;
            end else if (sleep_op) begin
                arith_and_reset_flags[`CMF_ST_PD] <= 1'b0;
            end
        end
    end
endmodule

// ==== tb/cmf_mem_model.sv ====
// data and program memory partner of the core map
`timescale 1ns/1ps
module cmf_mem_model (
    input wire core_clk,
    input wire [11:0] dmem_addr,
    input wire dmem_rd,
    input wire dmem_we,
    input wire [7:0] dmem_wdata,
    output wire [7:0] dmem_rdata,
    output wire dmem_impl,
    input wire [14:0] pmem_addr,
    input wire pmem_rd,
    output wire [13:0] pmem_rdata
);
    reg [7:0] ram [0:2047];
    reg [7:0] junk = 8'h00;
    reg dhold = 1'b0;
    reg [1:0] pcnt = 2'h0;
    reg [13:0] pword = 14'h0000;
    wire dval = dmem_rd | dhold;
    // answers only around a strobe, noise otherwise
    assign dmem_impl = dval ? !dmem_addr[11] : junk[0];
    assign dmem_rdata = dval ? ram[dmem_addr[10:0]] : junk;
    assign pmem_rdata = (pcnt != 2'h0) ? pword : {junk, junk[5:0]};
    // upper banks alias lower ones but report unimplemented
    always @(posedge core_clk) begin
        junk <= junk + 8'h5b;
        dhold <= dmem_rd;
        if (dmem_we && !dmem_addr[11]) begin
            ram[dmem_addr[10:0]] <= dmem_wdata;
        end
        if (pmem_rd) begin
            pcnt <= 2'h2;
            pword <= pmem_addr[13:0] ^ 14'h1555;
        end else if (pcnt != 2'h0) begin
            pcnt <= pcnt - 2'h1;
        end
    end
endmodule

// ==== tb/cmf_core_map_asserts.sv ====
// port assertions for the core map
`timescale 1ns/1ps
module cmf_core_map_chk #(
    parameter PC_W = 15
) (
    input wire core_clk,
    input wire nrst,
    input wire pc_step,
    input wire pc_jump,
    input wire pc_call,
    input wire pc_return,
    input wire int_entry,
    input wire [PC_W-1:0] pc_target,
    input wire [PC_W-1:0] prog_counter,
    input wire access_req,
    input wire access_done,
    input wire [7:0] access_rdata,
    input wire pmem_rd,
    input wire [13:0] pmem_rdata,
    input wire watchdog_clear_op,
    input wire sleep_op,
    input wire watchdog_timeout,
    input wire [7:0] arith_and_reset_flags,
    input wire soft_reset,
    input wire stack_err_reset_en,
    input wire stack_overflow_flag,
    input wire stack_underflow_flag
);
    wire [7:0] plow = pmem_rdata[7:0];
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    a_pc_in_range: assert property (prog_counter <= 15'h0fff)
        else $error("pc beyond last word");
    a_reset_vector: assert property ($rose(nrst) |-> prog_counter == 0)
        else $error("pc not at reset vector");
    a_int_vector: assert property (int_entry |=> prog_counter == 15'h0004)
        else $error("interrupt vector wrong");
    a_jump_wraps: assert property ((pc_jump || pc_call) && !int_entry
        |=> prog_counter == ($past(pc_target) & 15'h0fff))
        else $error("jump target not wrapped");
    a_step_incr: assert property (pc_step && !(pc_jump || pc_call
        || pc_return || int_entry || access_req)
        |=> prog_counter == (($past(prog_counter) + 15'h1) & 15'h0fff))
        else $error("pc step wrong");
    a_status_zeros: assert property (arith_and_reset_flags[7:5] == 0)
        else $error("status top bits not zero");
    a_ro_bits_hold: assert property (!(watchdog_clear_op || sleep_op
        || watchdog_timeout) |=> $stable(arith_and_reset_flags[4:3]))
        else $error("reset status bits moved");
    a_prog_latency: assert property (pmem_rd |-> !access_done
        ##1 !access_done ##1 access_done)
        else $error("program read latency wrong");
    a_prog_low_byte: assert property (pmem_rd ##2 1'b1
        |-> access_rdata == $past(plow))
        else $error("program read byte wrong");
    a_soft_cause: assert property (soft_reset |-> $past(stack_err_reset_en)
        && (stack_overflow_flag || stack_underflow_flag))
        else $error("soft reset without stack error");
    c_prog_read: cover property (pmem_rd);
    c_soft: cover property (soft_reset);
    c_int: cover property (int_entry ##1 1'b1);
endmodule
bind cmf_core_map cmf_core_map_chk #(.PC_W(PC_W)) u_chk (
    .core_clk, .nrst, .pc_step, .pc_jump, .pc_call, .pc_return,
    .int_entry, .pc_target, .prog_counter, .access_req, .access_done,
    .access_rdata, .pmem_rd, .pmem_rdata, .watchdog_clear_op, .sleep_op,
    .watchdog_timeout, .arith_and_reset_flags, .soft_reset,
    .stack_err_reset_en, .stack_overflow_flag, .stack_underflow_flag
);

// ==== tb/test_cmf_core_map.sv ====
// self-checking bench for the core map
`timescale 1ns/1ps
module test_cmf_core_map;
    reg core_clk, seen;
    reg nrst = 1'b0, stack_err_reset_en = 1'b0, access_req = 1'b0;
    reg access_ind = 1'b0, access_ptr = 1'b0, access_wr = 1'b0;
    reg [9:0] ev = 10'h000;
    reg [14:0] pc_target = 15'h0000;
    reg [6:0] access_addr = 7'h00;
    reg [7:0] access_wdata = 8'h00, flag_a = 8'h00, flag_b = 8'h00;
    reg [7:0] flag_logic_res = 8'h00, r;
    reg [1:0] flag_op = 2'h0;
    wire [14:0] prog_counter, pmem_addr;
    wire stack_overflow_flag, stack_underflow_flag, soft_reset;
    wire access_busy, access_done, dmem_rd, dmem_we, dmem_impl, pmem_rd;
    wire [7:0] access_rdata, dmem_wdata, dmem_rdata, arith_and_reset_flags;
    wire [11:0] dmem_addr;
    wire [13:0] pmem_rdata;
    wire [4:0] bank_select_reg;
    integer error_cnt = 0, num_checks = 0, we_cnt = 0, n, k;
    cmf_core_map u_dut (
        .core_clk, .nrst, .pc_step(ev[0]), .pc_jump(ev[1]),
        .pc_call(ev[2]), .pc_return(ev[3]), .int_entry(ev[4]),
        .pc_target, .prog_counter, .stack_err_reset_en,
        .stack_flag_clear(ev[9]), .stack_overflow_flag,
        .stack_underflow_flag, .soft_reset, .access_req, .access_ind,
        .access_ptr, .access_wr, .access_addr, .access_wdata,
        .access_busy, .access_done, .access_rdata, .dmem_addr, .dmem_rd,
        .dmem_we, .dmem_wdata, .dmem_rdata, .dmem_impl, .pmem_addr,
        .pmem_rd, .pmem_rdata, .flag_upd(ev[8]), .flag_op, .flag_a,
        .flag_b, .flag_logic_res, .watchdog_clear_op(ev[5]),
        .sleep_op(ev[6]), .watchdog_timeout(ev[7]),
        .arith_and_reset_flags, .bank_select_reg
    );
    cmf_mem_model u_mem (
        .core_clk, .dmem_addr, .dmem_rd, .dmem_we, .dmem_wdata,
        .dmem_rdata, .dmem_impl, .pmem_addr, .pmem_rd, .pmem_rdata
    );
    // clock and data write counter
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (dmem_we === 1'b1) we_cnt = we_cnt + 1;
    // verdict and end of run
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // one-cycle event pulse
    task pul(input [9:0] m, input [14:0] t);
        begin
            @(posedge core_clk);
            ev <= m;
            pc_target <= t;
            @(posedge core_clk);
            ev <= 10'h000;
            #1;
        end
    endtask
    task rst;
        begin
            @(posedge core_clk);
            nrst <= 1'b0;
            repeat (20) @(posedge core_clk);
            nrst <= 1'b1;
            #1;
        end
    endtask
    // file access; n: cycles to done, r: data
    task acc(input i, input p, input w, input [6:0] a, input [7:0] d,
        input fu);
        begin
            @(posedge core_clk);
            access_ind <= i;
            access_ptr <= p;
            access_wr <= w;
            access_addr <= a;
            access_wdata <= d;
            access_req <= 1'b1;
            ev[8] <= fu;
            @(posedge core_clk);
            access_req <= 1'b0;
            ev[8] <= 1'b0;
            n = 1;
            #1;
            while (access_done !== 1'b1 && n < 8) begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            if (n >= 8) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: access hung", $time);
                wrap_up;
            end
            r = access_rdata;
        end
    endtask
    task watch_soft;
        begin
            seen = 1'b0;
            for (k = 0; k < 3; k = k + 1) begin
                seen = seen | (soft_reset === 1'b1);
                @(posedge core_clk);
                #1;
            end
        end
    endtask
    task t_pc;
        begin
            chk(prog_counter, 15'h0000);
            chk(arith_and_reset_flags, 8'h18);
            pul(10'h002, 15'h7ffe);
            chk(prog_counter, 15'h0ffe);
            pul(10'h001, 15'h0000);
            pul(10'h001, 15'h0000);
            chk(prog_counter, 15'h0000);
            pul(10'h002, 15'h0010);
            pul(10'h004, 15'h0123);
            pul(10'h010, 15'h0000);
            chk(prog_counter, 15'h0004);
            pul(10'h008, 15'h0000);
            chk(prog_counter, 15'h0123);
            pul(10'h008, 15'h0000);
            chk(prog_counter, 15'h0011);
            acc(1'b0, 1'b0, 1'b1, 7'h0a, 8'h1f, 1'b0);
            acc(1'b0, 1'b0, 1'b1, 7'h02, 8'h34, 1'b0);
            chk(prog_counter, 15'h0f34);
            $display("test pc done");
        end
    endtask
    task t_stack;
        begin
            @(posedge core_clk);
            stack_err_reset_en <= 1'b1;
            for (k = 0; k < 16; k = k + 1) pul(10'h004, 15'h0100);
            chk(stack_overflow_flag, 1'b0);
            pul(10'h004, 15'h0100);
            watch_soft;
            chk({seen, stack_overflow_flag}, 2'b11);
            pul(10'h200, 15'h0000);
            chk(stack_overflow_flag, 1'b0);
            @(posedge core_clk);
            stack_err_reset_en <= 1'b0;
            rst;
            pul(10'h008, 15'h0000);
            watch_soft;
            chk({seen, stack_underflow_flag}, 2'b01);
            $display("test stack done");
        end
    endtask
    task t_bank;
        begin
            acc(1'b0, 1'b0, 1'b1, 7'h08, 8'h05, 1'b0);
            chk({n[3:0], bank_select_reg}, {4'h1, 5'h05});
            acc(1'b0, 1'b0, 1'b1, 7'h20, 8'ha5, 1'b0);
            chk({dmem_addr, dmem_wdata}, 20'h2a0a5);
            acc(1'b0, 1'b0, 1'b0, 7'h20, 8'h00, 1'b0);
            chk({n[3:0], r}, 12'h2a5);
            acc(1'b0, 1'b0, 1'b0, 7'h03, 8'h00, 1'b0);
            chk({n[3:0], r}, 12'h118);
            acc(1'b0, 1'b0, 1'b1, 7'h08, 8'h15, 1'b0);
            acc(1'b0, 1'b0, 1'b0, 7'h20, 8'h00, 1'b0);
            chk({dmem_addr, r}, 20'haa000);
            $display("test bank done");
        end
    endtask
    task t_ptr;
        begin
            acc(1'b0, 1'b0, 1'b1, 7'h04, 8'h23, 1'b0);
            acc(1'b0, 1'b0, 1'b1, 7'h05, 8'h81, 1'b0);
            acc(1'b1, 1'b0, 1'b0, 7'h00, 8'h00, 1'b0);
            chk({n[3:0], r}, 12'h376);
            chk(pmem_addr, 15'h0123);
            k = we_cnt;
            acc(1'b1, 1'b0, 1'b1, 7'h00, 8'h5a, 1'b0);
            chk({n[3:0], we_cnt[11:0]}, {4'h1, k[11:0]});
            acc(1'b0, 1'b0, 1'b1, 7'h06, 8'h34, 1'b0);
            acc(1'b0, 1'b0, 1'b1, 7'h07, 8'h02, 1'b0);
            acc(1'b1, 1'b1, 1'b1, 7'h00, 8'h3c, 1'b0);
            chk(dmem_addr, 12'h234);
            acc(1'b0, 1'b0, 1'b0, 7'h01, 8'h00, 1'b0);
            chk({n[3:0], r}, 12'h23c);
            $display("test pointer done");
        end
    endtask
    task fl(input [1:0] o, input [7:0] a, input [7:0] b, input [7:0] l,
        input [2:0] e);
        begin
            @(posedge core_clk);
            flag_op <= o;
            flag_a <= a;
            flag_b <= b;
            flag_logic_res <= l;
            pul(10'h100, 15'h0000);
            chk(arith_and_reset_flags[2:0], e);
        end
    endtask
    task t_flags;
        begin
            fl(2'h0, 8'h0f, 8'h01, 8'h00, 3'h2);
            fl(2'h0, 8'hff, 8'h01, 8'h00, 3'h7);
            fl(2'h0, 8'h80, 8'h80, 8'h00, 3'h5);
            fl(2'h1, 8'h05, 8'h05, 8'h00, 3'h7);
            fl(2'h1, 8'h03, 8'h05, 8'h00, 3'h0);
            fl(2'h1, 8'h10, 8'h01, 8'h00, 3'h1);
            fl(2'h2, 8'h00, 8'h00, 8'h00, 3'h5);
            fl(2'h2, 8'h00, 8'h00, 8'h3c, 3'h1);
            fl(2'h0, 8'h00, 8'h00, 8'h00, 3'h4);
            acc(1'b0, 1'b0, 1'b1, 7'h03, 8'hff, 1'b1);
            chk(arith_and_reset_flags, 8'h1c);
            acc(1'b0, 1'b0, 1'b1, 7'h03, 8'he2, 1'b0);
            chk(arith_and_reset_flags, 8'h1a);
            $display("test flags done");
        end
    endtask
    task t_wdt;
        begin
            pul(10'h080, 15'h0000);
            chk(arith_and_reset_flags[4:3], 2'b01);
            pul(10'h040, 15'h0000);
            chk(arith_and_reset_flags[4:3], 2'b10);
            pul(10'h0c0, 15'h0000);
            chk(arith_and_reset_flags[4:3], 2'b10);
            pul(10'h020, 15'h0000);
            chk(arith_and_reset_flags[4:3], 2'b11);
            $display("test watchdog done");
        end
    endtask
    initial begin
        rst;
        t_pc;
        t_stack;
        t_bank;
        t_ptr;
        t_flags;
        t_wdt;
        wrap_up;
    end
endmodule
